// ---- pkg/strap_cfg_regs.svh ----
/*
 Constants for the strap sampling and mode configuration block.
 Assumes inclusion by bare name from the decode and top design files.
*/
`ifndef STRAP_CFG_REGS_SVH
`define STRAP_CFG_REGS_SVH
// Operating mode strap codes
`define OPMODE_DUAL_HDX 3'h0
`define OPMODE_RSVD_1 3'h1
`define OPMODE_RSVD_2 3'h2
`define OPMODE_10_HDX 3'h3
`define OPMODE_10_FDX 3'h4
`define OPMODE_100_HDX 3'h5
`define OPMODE_100_FDX 3'h6
`define OPMODE_AUTO_ALL 3'h7
// Reset values of captured straps
`define OPMODE_RST 3'h7
`define IFSTRAP_RST 1'h0
`define SERSTRAP_RST 1'h1
`define STSSTRAP_RST 1'h0
// Advertised ability bit positions
`define ADV_10_HDX_BIT 0
`define ADV_10_FDX_BIT 1
`define ADV_100_HDX_BIT 2
`define ADV_100_FDX_BIT 3
`endif

// ---- pkg/strap_cfg_pkg.sv ----
/*
 Types for the strap sampling and mode configuration block.
 Assumes no surroundings beyond the compile order.
*/
package strap_cfg_pkg;
  // MAC-side pin map
  typedef enum logic [1:0] {
    MAP_MII,
    MAP_RMII,
    MAP_SERIAL
  } pin_map_t;
  // Strap capture phase
  typedef enum logic [1:0] {
    PH_RESET,
    PH_CAPTURE,
    PH_RUN
  } phase_t;
endpackage : strap_cfg_pkg

// ---- core/opmode_decode.sv ----
/*
 Decodes a captured operating-mode strap code into speed, duplex and
 auto-negotiation settings. Assumes a stable, registered code input.
*/
`include "strap_cfg_regs.svh"
module opmode_decode (
  input wire logic [2:0] code_in,
  output logic autoneg_out,
  output logic speed100_out,
  output logic full_duplex_out,
  output logic [3:0] advert_out,
  output logic reserved_out
);
  // Decode of the eight codes
  always_comb begin
    autoneg_out = 1'b0;
    speed100_out = 1'b0;
    full_duplex_out = 1'b0;
    advert_out = 4'h0;
    reserved_out = 1'b0;
    case (code_in)
      `OPMODE_DUAL_HDX: begin
        autoneg_out = 1'b1;
        speed100_out = 1'b1;
        advert_out[`ADV_10_HDX_BIT] = 1'b1; // RULE_02
        advert_out[`ADV_100_HDX_BIT] = 1'b1; // RULE_02
      end
      `OPMODE_10_HDX: begin
        advert_out[`ADV_10_HDX_BIT] = 1'b1; // RULE_03
      end
      `OPMODE_10_FDX: begin
        full_duplex_out = 1'b1; // RULE_03
        advert_out[`ADV_10_FDX_BIT] = 1'b1;
      end
      `OPMODE_100_HDX: begin
        speed100_out = 1'b1; // RULE_03
        advert_out[`ADV_100_HDX_BIT] = 1'b1;
      end
      `OPMODE_100_FDX: begin
        speed100_out = 1'b1; // RULE_03
        full_duplex_out = 1'b1;
        advert_out[`ADV_100_FDX_BIT] = 1'b1;
      end
      `OPMODE_AUTO_ALL: begin
        autoneg_out = 1'b1; // RULE_04
        speed100_out = 1'b1;
        full_duplex_out = 1'b1;
        advert_out = 4'hf; // RULE_04
      end
      default: begin
        reserved_out = 1'b1; // RULE_02
      end
    endcase
  end
endmodule : opmode_decode

// ---- core/phy_strap_mode_config.sv ----
/*
 Strap sampling and operating-mode configuration for a 10/100 transceiver:
 captures straps after reset, decodes mode, handles power-down, cable or
 link indicator and MAC pin-map gating. Assumes synchronous inputs on clk_in.
*/
// Functional notes
// [RULE_01] Sample three opmode straps at reset and hold them as mode setting.
// [RULE_02] Code 000 gives dual speed half duplex; 001 and 010 reserved.
// [RULE_03] Codes 011..110 force 10H, 10F, 100H, 100F without negotiation.
// [RULE_04] Code 111 enables auto-negotiation advertising all abilities.
// [RULE_05] Power-down disables functions, keeps management alive, quiet MAC side.
// [RULE_06] Power-down exits only on a reset taken with power-down low.
// [RULE_07] Indicator strapped low shows cable presence, 1 when attached.
// [RULE_08] Indicator strapped high shows link, 0 when link up.
// [RULE_09] Crossover disable high turns pair swapping off, low enables it.
// [RULE_10] Reduced MII uses two data bits, tx enable, carrier/valid only.
// [RULE_11] Serial mode uses bit 0 data, enable, clocks, collision, carrier.
// [RULE_12] Board supplies 25 MHz crystal, or 50 MHz reference in RMII.
// [RULE_13] Collision pin strap: low normal MII, high reduced MII.
// [RULE_14] Receive clock pin strap: 0 serial 10M mode, 1 nibble MII.
// [RULE_15] Device initialises while the active-low reset is asserted.
// [RULE_16] Straps captured at reset release and held until next reset.
`include "strap_cfg_regs.svh"
module phy_strap_mode_config #(
  parameter int DATA_W = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic opmode_strap_bit0_in,
  input wire logic opmode_strap_bit1_in,
  input wire logic opmode_strap_bit2_in,
  input wire logic rmii_strap_in,
  input wire logic serial_10m_select_strap_in,
  input wire logic indicator_strap_in,
  input wire logic power_down_in,
  input wire logic soft_reset_in,
  input wire logic crossover_auto_off_in,
  input wire logic cable_present_in,
  input wire logic link_up_in,
  input wire logic [DATA_W-1:0] rx_data_in,
  input wire logic rx_valid_in,
  input wire logic rx_err_in,
  input wire logic carrier_in,
  input wire logic collision_in,
  input wire logic [DATA_W-1:0] tx_data_in,
  input wire logic tx_en_in,
  output logic strap_done_out,
  output logic [2:0] opmode_out,
  output logic autoneg_out,
  output logic speed100_out,
  output logic full_duplex_out,
  output logic [3:0] advert_out,
  output logic reserved_code_out,
  output logic [1:0] pin_map_out,
  output logic power_down_out,
  output logic auto_crossover_out,
  output logic cable_or_link_indicator_out,
  output logic cable_or_link_indicator_oe_out,
  output logic [DATA_W-1:0] mac_rxd_out,
  output logic mac_rx_valid_out,
  output logic mac_rx_err_out,
  output logic mac_carrier_out,
  output logic mac_collision_out,
  output logic [DATA_W-1:0] phy_txd_out,
  output logic phy_tx_en_out
);
  // Elaboration check: the pin maps below are written for a nibble-wide data path
  if (DATA_W != 4) begin : g_width_check
    $error("DATA_W must be 4 for nibble MII");
  end

  strap_cfg_pkg::phase_t phase_r, phase_nxt;
  logic [2:0] opmode_r;
  logic ifstrap_r;
  logic serstrap_r;
  logic stsstrap_r;
  logic pd_r, pd_nxt;
  logic dec_autoneg, dec_speed100, dec_fdx, dec_rsvd;
  logic [3:0] dec_adv;
  strap_cfg_pkg::pin_map_t map_w;
  logic run_w;
  logic quiet_w;
  logic ind_w;
  logic [DATA_W-1:0] rxd_w, txd_w;
  logic rxv_w, rxe_w, crs_w, col_w;

  // Mode decode of the held strap code
  opmode_decode u_dec (
    .code_in(opmode_r),
    .autoneg_out(dec_autoneg),
    .speed100_out(dec_speed100),
    .full_duplex_out(dec_fdx),
    .advert_out(dec_adv),
    .reserved_out(dec_rsvd)
  );

  // Phase: reset holds, first cycle after release captures, then run
  always_comb begin
    case (phase_r)
      strap_cfg_pkg::PH_RESET: phase_nxt = strap_cfg_pkg::PH_CAPTURE;
      strap_cfg_pkg::PH_CAPTURE: phase_nxt = strap_cfg_pkg::PH_RUN;
      strap_cfg_pkg::PH_RUN: phase_nxt = soft_reset_in ? strap_cfg_pkg::PH_RESET
                                                       : strap_cfg_pkg::PH_RUN;
      default: phase_nxt = strap_cfg_pkg::PH_RESET;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      phase_r <= strap_cfg_pkg::PH_RESET; // RULE_15
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // Strap capture at release; hard reset re-captures, soft reset keeps straps
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      opmode_r <= `OPMODE_RST;
      ifstrap_r <= `IFSTRAP_RST;
      serstrap_r <= `SERSTRAP_RST;
      stsstrap_r <= `STSSTRAP_RST;
    end else if (phase_r == strap_cfg_pkg::PH_CAPTURE && !strap_done_out) begin
      opmode_r <= {opmode_strap_bit2_in, opmode_strap_bit1_in,
                   opmode_strap_bit0_in}; // RULE_01 RULE_16
      ifstrap_r <= rmii_strap_in; // RULE_13
      serstrap_r <= serial_10m_select_strap_in; // RULE_14
      stsstrap_r <= indicator_strap_in;
    end
  end

  // Power-down: enters on pin high, leaves only through a reset with pin low
  assign pd_nxt = power_down_in ? 1'b1 :
                  (phase_r == strap_cfg_pkg::PH_RESET) ? 1'b0 : pd_r; // RULE_06
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pd_r <= 1'b0;
    end else begin
      pd_r <= pd_nxt; // RULE_05
    end
  end

  // Pin map selection and gating
  assign map_w = ifstrap_r ? strap_cfg_pkg::MAP_RMII :
                 (!serstrap_r && !dec_speed100) ? strap_cfg_pkg::MAP_SERIAL
                                                : strap_cfg_pkg::MAP_MII;
  assign run_w = (phase_r == strap_cfg_pkg::PH_RUN);
  assign quiet_w = pd_nxt || !run_w; // RULE_05
  assign ind_w = stsstrap_r ? !link_up_in : cable_present_in; // RULE_07 RULE_08

  // MAC-side data per map
  always_comb begin
    rxd_w = rx_data_in;
    txd_w = tx_data_in;
    rxv_w = rx_valid_in;
    rxe_w = rx_err_in;
    crs_w = carrier_in;
    col_w = collision_in;
    case (map_w)
      strap_cfg_pkg::MAP_RMII: begin
        rxd_w = {2'h0, rx_data_in[1:0]}; // RULE_10
        txd_w = {2'h0, tx_data_in[1:0]};
        rxv_w = rx_valid_in || carrier_in; // RULE_10
        rxe_w = 1'b0;
        crs_w = 1'b0;
        col_w = 1'b0;
      end
      strap_cfg_pkg::MAP_SERIAL: begin
        rxd_w = {3'h0, rx_data_in[0]}; // RULE_11
        txd_w = {3'h0, tx_data_in[0]};
        rxv_w = 1'b0; // RULE_11
        rxe_w = 1'b0;
      end
      default: begin
        rxd_w = rx_data_in;
      end
    endcase
  end

  // Registered outputs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      strap_done_out <= 1'b0;
      opmode_out <= `OPMODE_RST;
      autoneg_out <= 1'b0;
      speed100_out <= 1'b0;
      full_duplex_out <= 1'b0;
      advert_out <= 4'h0;
      reserved_code_out <= 1'b0;
      pin_map_out <= 2'h0;
      power_down_out <= 1'b0;
      auto_crossover_out <= 1'b0;
      cable_or_link_indicator_out <= 1'b0;
      cable_or_link_indicator_oe_out <= 1'b0;
      mac_rxd_out <= '0;
      mac_rx_valid_out <= 1'b0;
      mac_rx_err_out <= 1'b0;
      mac_carrier_out <= 1'b0;
      mac_collision_out <= 1'b0;
      phy_txd_out <= '0;
      phy_tx_en_out <= 1'b0;
    end else begin
      strap_done_out <= strap_done_out || (phase_r == strap_cfg_pkg::PH_CAPTURE);
      opmode_out <= opmode_r;
      autoneg_out <= dec_autoneg; // RULE_01
      speed100_out <= dec_speed100;
      full_duplex_out <= dec_fdx;
      advert_out <= dec_adv;
      reserved_code_out <= dec_rsvd;
      pin_map_out <= map_w;
      power_down_out <= pd_nxt;
      auto_crossover_out <= !crossover_auto_off_in && !pd_nxt; // RULE_09
      cable_or_link_indicator_out <= run_w && !pd_nxt && ind_w;
      cable_or_link_indicator_oe_out <= run_w; // RULE_16
      mac_rxd_out <= quiet_w ? '0 : rxd_w;
      mac_rx_valid_out <= !quiet_w && rxv_w;
      mac_rx_err_out <= !quiet_w && rxe_w;
      mac_carrier_out <= !quiet_w && crs_w;
      mac_collision_out <= !quiet_w && col_w;
      phy_txd_out <= quiet_w ? '0 : txd_w;
      phy_tx_en_out <= !quiet_w && tx_en_in;
    end
  end

  // Strap code is held while running
  AST_STRAP_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (phase_r == strap_cfg_pkg::PH_RUN && $past(phase_r) == strap_cfg_pkg::PH_RUN)
    |-> $stable(opmode_r)) else $error("Strap code changed while running"); // RULE_16
  // Captured code follows the pins one edge after capture phase
  AST_CAPTURE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (phase_r == strap_cfg_pkg::PH_CAPTURE && !strap_done_out) |=>
    opmode_r == $past({opmode_strap_bit2_in, opmode_strap_bit1_in,
                       opmode_strap_bit0_in})) else $error("Strap capture wrong"); // RULE_01
  // Auto code advertises everything
  AST_AUTO_ALL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (opmode_r == `OPMODE_AUTO_ALL) |=> (advert_out == 4'hf && autoneg_out))
    else $error("Auto code lacks full advert"); // RULE_04
  // Forced codes never negotiate
  AST_FORCED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (opmode_r inside {`OPMODE_10_HDX, `OPMODE_10_FDX, `OPMODE_100_HDX,
                      `OPMODE_100_FDX}) |=> !autoneg_out)
    else $error("Forced mode negotiates"); // RULE_03
  // Code zero is dual speed half duplex
  AST_DUAL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (opmode_r == `OPMODE_DUAL_HDX) |=> (advert_out == 4'h5 && !full_duplex_out))
    else $error("Dual speed decode wrong"); // RULE_02
  // Power-down silences MAC side and stays until reset
  AST_PD_QUIET: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    power_down_in |=> (power_down_out && !mac_rx_valid_out && !mac_carrier_out))
    else $error("Activity in power-down"); // RULE_05
  AST_PD_STICKY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pd_r && phase_r == strap_cfg_pkg::PH_RUN && !soft_reset_in) |=> pd_r)
    else $error("Power-down left without reset"); // RULE_06
  // Indicator polarity follows strap
  AST_INDICATOR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (run_w && !pd_nxt) |=> cable_or_link_indicator_out ==
    ($past(stsstrap_r) ? !$past(link_up_in) : $past(cable_present_in)))
    else $error("Indicator polarity wrong"); // RULE_07 RULE_08
  // Crossover control
  AST_MDIX: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    crossover_auto_off_in |=> !auto_crossover_out)
    else $error("Crossover not disabled"); // RULE_09
  // Reduced map blanks upper bits and collision
  AST_RMII: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (map_w == strap_cfg_pkg::MAP_RMII) |=> (mac_rxd_out[3:2] == 2'h0 && !mac_collision_out))
    else $error("Reduced map leaks pins"); // RULE_10 RULE_13
  // Serial map uses bit 0 and no valid
  AST_SERIAL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (map_w == strap_cfg_pkg::MAP_SERIAL) |=> (mac_rxd_out[3:1] == 3'h0 && !mac_rx_valid_out))
    else $error("Serial map leaks pins"); // RULE_11 RULE_14
endmodule : phy_strap_mode_config

// ---- bench/mac_partner.sv ----
/*
 MAC-side partner: drives transmit nibbles and keeps the last valid
 receive nibble. Assumes the block's clock and synchronous reset.
*/
module mac_partner (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic send_in,
  input wire logic [3:0] nib_in,
  input wire logic [3:0] rxd_in,
  input wire logic rx_valid_in,
  output logic [3:0] txd_out,
  output logic tx_en_out,
  output logic [3:0] rx_seen_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle data alternates each cycle between the inverse of the last nibble and the nibble itself
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      txd_out <= 4'h0;
      tx_en_out <= 1'b0;
      rx_seen_out <= 4'h0;
    end else begin
      tx_en_out <= send_in;
      txd_out <= send_in ? nib_in : ~txd_out;
      if (rx_valid_in) rx_seen_out <= rxd_in;
    end
  end
endmodule : mac_partner

// ---- bench/tb_phy_strap_mode_config.sv ----
/*
 Self-checking bench for strap capture, mode decode, power-down and
 pin-map gating. Assumes the partner model and the design's defaults.
*/
module tb_phy_strap_mode_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, rm, ser, ind_s, pd, sr, xo, cab, lnk, rxv, rxe, crs, col, send;
  logic [2:0] code;
  logic [3:0] rxd, nib, mtxd, seen, adv, mrxd, ptxd;
  logic done, an, s100, fdx, rsv, pdo, axo, ind, oe, mrxv, mrxe, mcrs, mcol, pten, mten;
  logic [2:0] opm;
  logic [1:0] map;
  int err_count;
  int comparisons;
  // Clock at 250 MHz
  always #2 clk = ~clk;
  phy_strap_mode_config dut (.clk_in(clk), .rst_n_in(rst_n),
    .opmode_strap_bit0_in(code[0]), .opmode_strap_bit1_in(code[1]),
    .opmode_strap_bit2_in(code[2]), .rmii_strap_in(rm),
    .serial_10m_select_strap_in(ser), .indicator_strap_in(ind_s),
    .power_down_in(pd), .soft_reset_in(sr), .crossover_auto_off_in(xo),
    .cable_present_in(cab), .link_up_in(lnk), .rx_data_in(rxd), .rx_valid_in(rxv),
    .rx_err_in(rxe), .carrier_in(crs), .collision_in(col), .tx_data_in(mtxd),
    .tx_en_in(mten), .strap_done_out(done), .opmode_out(opm), .autoneg_out(an),
    .speed100_out(s100), .full_duplex_out(fdx), .advert_out(adv),
    .reserved_code_out(rsv), .pin_map_out(map), .power_down_out(pdo),
    .auto_crossover_out(axo), .cable_or_link_indicator_out(ind),
    .cable_or_link_indicator_oe_out(oe), .mac_rxd_out(mrxd), .mac_rx_valid_out(mrxv),
    .mac_rx_err_out(mrxe), .mac_carrier_out(mcrs), .mac_collision_out(mcol),
    .phy_txd_out(ptxd), .phy_tx_en_out(pten));
  mac_partner mac (.clk_in(clk), .rst_n_in(rst_n), .send_in(send), .nib_in(nib),
    .rxd_in(mrxd), .rx_valid_in(mrxv), .txd_out(mtxd), .tx_en_out(mten),
    .rx_seen_out(seen));
  // Verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  // Compare one value and report a mismatch
  task automatic chk(input string what, input logic [3:0] e, input logic [3:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // Hard reset with new straps, then bounded wait for capture
  task automatic hard_reset(input logic [2:0] c, input logic r, input logic s,
                            input logic i);
    int n;
    code <= c;
    rm <= r;
    ser <= s;
    ind_s <= i;
    rst_n <= 1'b0;
    step(6);
    chk("done_in_reset", 4'h0, 4'(done));
    chk("opmode_in_reset", 4'h7, 4'(opm));
    rst_n <= 1'b1;
    for (n = 0; n < 8 && done !== 1'b1; n++) step(1);
    if (done !== 1'b1) begin
      err_count++;
      $display("[ERR] strap_done expected 1 seen %b", done);
      summarize();
    end
    step(1);
  endtask : hard_reset
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {code, rm, ind_s, pd, sr, xo, cab, lnk, rxd, rxv, rxe, crs, col, send, nib} = '0;
    ser = 1'b1;
    // Every operating-mode code
    for (int c = 0; c < 8; c++) begin
      hard_reset(3'(c), 1'b0, 1'b1, 1'b0);
      chk("opmode", 4'(c), 4'(opm));
      chk("reserved", 4'(c == 1 || c == 2), 4'(rsv));
      chk("autoneg", 4'(c == 0 || c == 7), 4'(an));
      chk("pin_map", 4'h0, 4'(map));
      if (c > 2 && c < 7) chk("speed", 4'(c > 4), 4'(s100));
      if (c > 2 && c < 7) chk("duplex", 4'(c == 4 || c == 6), 4'(fdx));
      if (c == 0) chk("advert_dual", 4'h5, adv);
      if (c == 7) chk("advert_all", 4'hf, adv);
    end
    $display("test decode done");
    // Straps held across pin changes and soft reset
    code <= 3'h3;
    step(3);
    chk("opmode_held", 4'h7, 4'(opm));
    sr <= 1'b1;
    step(1);
    sr <= 1'b0;
    step(3);
    chk("opmode_soft", 4'h7, 4'(opm));
    $display("test hold done");
    // Cable indicator and crossover control
    cab <= 1'b1;
    step(2);
    chk("cable_on", 4'h1, 4'(ind));
    chk("ind_oe", 4'h1, 4'(oe));
    chk("xover_on", 4'h1, 4'(axo));
    cab <= 1'b0;
    xo <= 1'b1;
    step(2);
    chk("cable_off", 4'h0, 4'(ind));
    chk("xover_off", 4'h0, 4'(axo));
    hard_reset(3'h7, 1'b0, 1'b1, 1'b1);
    lnk <= 1'b1;
    step(2);
    chk("link_up", 4'h0, 4'(ind));
    lnk <= 1'b0;
    step(2);
    chk("link_down", 4'h1, 4'(ind));
    $display("test indicator done");
    // Reduced MII: two data bits, valid from carrier
    hard_reset(3'h7, 1'b1, 1'b1, 1'b0);
    chk("map_rmii", 4'h1, 4'(map));
    rxd <= 4'hf;
    rxv <= 1'b1;
    send <= 1'b1;
    nib <= 4'hf;
    step(3);
    chk("rmii_rxd", 4'h3, mrxd);
    chk("rmii_txd", 4'h3, ptxd);
    chk("rmii_seen", 4'h3, seen);
    rxv <= 1'b0;
    crs <= 1'b1;
    rxe <= 1'b1;
    step(2);
    chk("rmii_valid", 4'h1, 4'(mrxv));
    chk("rmii_crs", 4'h0, 4'(mcrs));
    chk("rmii_err", 4'h0, 4'(mrxe));
    chk("rmii_txen", 4'h1, 4'(pten));
    // Serial map only at 10 Mbps
    hard_reset(3'h3, 1'b0, 1'b0, 1'b0);
    chk("map_serial", 4'h2, 4'(map));
    step(2);
    chk("ser_rxd", 4'h1, mrxd);
    chk("ser_txd", 4'h1, ptxd);
    hard_reset(3'h6, 1'b0, 1'b0, 1'b0);
    chk("map_100", 4'h0, 4'(map));
    $display("test pin map done");
    // Power-down silences the MAC side until a reset with the pin low
    col <= 1'b1;
    rxv <= 1'b1;
    cab <= 1'b1;
    pd <= 1'b1;
    step(2);
    chk("pd_out", 4'h1, 4'(pdo));
    chk("pd_rxd", 4'h0, mrxd);
    chk("pd_ctl", 4'h0, {mrxv, mcrs, mcol, ind});
    pd <= 1'b0;
    step(2);
    chk("pd_kept", 4'h1, 4'(pdo));
    sr <= 1'b1;
    step(1);
    sr <= 1'b0;
    step(3);
    chk("pd_exit", 4'h0, 4'(pdo));
    chk("pd_rxd_back", 4'hf, mrxd);
    chk("pd_ctl_back", 4'hf, {mrxv, mcrs, mcol, mrxe});
    chk("pd_txd_back", 4'hf, ptxd);
    chk("pd_txen_back", 4'h1, 4'(pten));
    chk("pd_ind_back", 4'h1, 4'(ind));
    $display("test power down done");
    summarize();
  end
endmodule : tb_phy_strap_mode_config
